// File: src/uams_top.sv
/*
 Serial port slice: hardware slave-address filter for deframed asynchronous frames and
 the synchronous shift engine (two-wire and three-wire), behind an AXI4-Lite slave.
 Assumes the asynchronous receiver delivers whole frames on sys_clk_i as a one-cycle
 valid, and that timer1_ovf_i is a one-cycle pulse on the same clock.
*/
`timescale 1ns/1ps
`include "uams_defines.svh"

module uams_top (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // AXI4-Lite write
   input wire logic [11:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Deframed asynchronous receive and rate source
   input wire uams_pkg::uams_frame_t rx_frame_i,
   input wire logic timer1_ovf_i,
   // Two-wire pins
   input wire logic rxd_i,
   output logic rxd_o,
   output logic rxd_oe_o,
   output logic txd_o,
   // Three-wire pins
   input wire logic miso_i,
   output logic mosi_o,
   output logic sck_o,
   // Interrupt
   output logic irq_o
);

   function automatic uams_pkg::uams_reg_t decode(input logic [11:0] addr);
      if (addr[11:2] == `UAMS_WIDX_CTRL) begin
         decode = uams_pkg::UAMS_R_CTRL;
      end else if (addr[11:2] == `UAMS_WIDX_DATA) begin
         decode = uams_pkg::UAMS_R_DATA;
      end else if (addr[11:2] == `UAMS_WIDX_STATUS) begin
         decode = uams_pkg::UAMS_R_STATUS;
      end else if (addr[11:2] == `UAMS_WIDX_IRQ_MASK) begin
         decode = uams_pkg::UAMS_R_IRQ_MASK;
      end else if (addr[11:2] == `UAMS_WIDX_SLV_ADDR) begin
         decode = uams_pkg::UAMS_R_SLV_ADDR;
      end else if (addr[11:2] == `UAMS_WIDX_SLV_MASK) begin
         decode = uams_pkg::UAMS_R_SLV_MASK;
      end else begin
         decode = uams_pkg::UAMS_R_NONE;
      end
   endfunction

   function automatic logic [7:0] reverse8(input logic [7:0] v);
      reverse8 = 8'h00;
      for (int i = 0; i < 8; i++) begin
         reverse8[i] = v[7 - i];
      end
   endfunction

   // Bus state.
   logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
   logic [11:0] aw_addr_reg, aw_addr_next;
   logic [31:0] w_data_reg, w_data_next;
   logic [3:0] w_strb_reg, w_strb_next;
   logic awready_reg, awready_next, wready_reg, wready_next;
   logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, arready_reg, arready_next;
   logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
   logic [31:0] rdata_reg, rdata_next;
   // Software registers and flags.
   uams_pkg::uams_ctrl_t ctrl_reg, ctrl_next;
   logic [7:0] slv_addr_reg, slv_addr_next, slv_mask_reg, slv_mask_next;
   logic [7:0] rx_buf_reg, rx_buf_next;
   logic rb8_reg, rb8_next, ri_reg, ri_next, ti_reg, ti_next;
   logic [1:0] irq_mask_reg, irq_mask_next;
   logic irq_reg, irq_next;
   // Shift engine.
   uams_pkg::uams_state_t state_reg, state_next;
   logic [8:0] tx_sreg_reg, tx_sreg_next;
   logic [7:0] rx_sreg_reg, rx_sreg_next;
   logic tx_act_reg, tx_act_next, rx_act_reg, rx_act_next;
   logic [2:0] cnt_reg, cnt_next;
   // Pins.
   logic rxd_s1_reg, rxd_s2_reg, miso_s1_reg, miso_s2_reg;
   logic rxd_o_reg, rxd_o_next, rxd_oe_reg, rxd_oe_next, txd_reg, txd_next;
   logic mosi_reg, mosi_next, sck_reg, sck_next;

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_bvalid_o = bvalid_reg;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign rxd_o = rxd_o_reg;
   assign rxd_oe_o = rxd_oe_reg;
   assign txd_o = txd_reg;
   assign mosi_o = mosi_reg;
   assign sck_o = sck_reg;
   assign irq_o = irq_reg;

   always_comb begin
      uams_pkg::uams_reg_t wsel;
      uams_pkg::uams_reg_t rsel;
      logic do_write, data_wr, set_ri, set_ti, clr_ri, clr_ti;
      logic given_hit, bcast_hit, qualify, accept;
      logic src_ev, mid_ev, end_ev, chg_mid, tx_ev, rx_ev, din, idle_lvl, sclk;
      logic [2:0] per, half;
      logic [7:0] rx_shifted;
      wsel = uams_pkg::UAMS_R_NONE;
      rsel = uams_pkg::UAMS_R_NONE;
      do_write = 1'b0;
      data_wr = 1'b0;
      set_ri = 1'b0;
      set_ti = 1'b0;
      clr_ri = 1'b0;
      clr_ti = 1'b0;
      given_hit = 1'b0;
      bcast_hit = 1'b0;
      qualify = 1'b0;
      accept = 1'b0;
      rx_shifted = 8'h00;
      src_ev = 1'b0;
      mid_ev = 1'b0;
      end_ev = 1'b0;
      chg_mid = 1'b0;
      tx_ev = 1'b0;
      rx_ev = 1'b0;
      din = 1'b0;
      idle_lvl = 1'b1;
      sclk = 1'b1;
      per = 3'h0;
      half = 3'h0;
      aw_have_next = aw_have_reg;
      aw_addr_next = aw_addr_reg;
      w_have_next = w_have_reg;
      w_data_next = w_data_reg;
      w_strb_next = w_strb_reg;
      bvalid_next = bvalid_reg;
      bresp_next = bresp_reg;
      rvalid_next = rvalid_reg;
      rresp_next = rresp_reg;
      rdata_next = rdata_reg;
      ctrl_next = ctrl_reg;
      slv_addr_next = slv_addr_reg;
      slv_mask_next = slv_mask_reg;
      irq_mask_next = irq_mask_reg;
      rx_buf_next = rx_buf_reg;
      rb8_next = rb8_reg;
      state_next = state_reg;
      tx_sreg_next = tx_sreg_reg;
      rx_sreg_next = rx_sreg_reg;
      tx_act_next = tx_act_reg;
      rx_act_next = rx_act_reg;
      cnt_next = cnt_reg;

      // Address and data channels are taken independently; the write acts once both are in.
      if (s_axi_awvalid_i && awready_reg) begin
         aw_have_next = 1'b1;
         aw_addr_next = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_reg) begin
         w_have_next = 1'b1;
         w_data_next = s_axi_wdata_i;
         w_strb_next = s_axi_wstrb_i;
      end
      if (bvalid_reg && s_axi_bready_i) begin
         bvalid_next = 1'b0;
      end
      if (aw_have_reg && w_have_reg && !bvalid_reg) begin
         do_write = 1'b1;
         wsel = decode(aw_addr_reg);
         aw_have_next = 1'b0;
         w_have_next = 1'b0;
         bvalid_next = 1'b1;
         bresp_next = (wsel == uams_pkg::UAMS_R_NONE) ? `UAMS_RESP_SLVERR : `UAMS_RESP_OKAY;
      end
      if (do_write && w_strb_reg[0]) begin
         if (wsel == uams_pkg::UAMS_R_CTRL) begin
            ctrl_next[7:0] = w_data_reg[7:0];
         end else if (wsel == uams_pkg::UAMS_R_DATA) begin
            data_wr = 1'b1;
         end else if (wsel == uams_pkg::UAMS_R_STATUS) begin
            clr_ri = w_data_reg[`UAMS_ST_RX_DONE];
            clr_ti = w_data_reg[`UAMS_ST_TX_DONE];
         end else if (wsel == uams_pkg::UAMS_R_IRQ_MASK) begin
            irq_mask_next = w_data_reg[1:0];
         end else if (wsel == uams_pkg::UAMS_R_SLV_ADDR) begin
            slv_addr_next = w_data_reg[7:0];
         end else if (wsel == uams_pkg::UAMS_R_SLV_MASK) begin
            slv_mask_next = w_data_reg[7:0];
         end
      end
      if (do_write && w_strb_reg[1] && wsel == uams_pkg::UAMS_R_CTRL) begin
         ctrl_next[8] = w_data_reg[8];
      end

      // Reads answer one cycle after the address is taken.
      if (rvalid_reg && s_axi_rready_i) begin
         rvalid_next = 1'b0;
      end
      if (s_axi_arvalid_i && arready_reg) begin
         rsel = decode(s_axi_araddr_i);
         rvalid_next = 1'b1;
         rresp_next = `UAMS_RESP_OKAY;
         rdata_next = 32'h0000_0000;
         if (rsel == uams_pkg::UAMS_R_CTRL) begin
            rdata_next[8:0] = ctrl_reg;
         end else if (rsel == uams_pkg::UAMS_R_DATA) begin
            rdata_next[7:0] = rx_buf_reg;
         end else if (rsel == uams_pkg::UAMS_R_STATUS) begin
            rdata_next[`UAMS_ST_RX_DONE] = ri_reg;
            rdata_next[`UAMS_ST_TX_DONE] = ti_reg;
            rdata_next[`UAMS_ST_RB8] = rb8_reg;
         end else if (rsel == uams_pkg::UAMS_R_IRQ_MASK) begin
            rdata_next[1:0] = irq_mask_reg;
         end else if (rsel == uams_pkg::UAMS_R_SLV_ADDR) begin
            rdata_next[7:0] = slv_addr_reg;
         end else if (rsel == uams_pkg::UAMS_R_SLV_MASK) begin
            rdata_next[7:0] = slv_mask_reg;
         end else begin
            rresp_next = `UAMS_RESP_SLVERR;
         end
      end

      // Address filter for deframed asynchronous frames.
      given_hit = ((rx_frame_i.data ^ slv_addr_reg) & slv_mask_reg) == 8'h00;
      bcast_hit = (~rx_frame_i.data & (slv_addr_reg | slv_mask_reg)) == 8'h00;
      qualify = (ctrl_reg.mode == 2'h1) ? rx_frame_i.stop_ok : rx_frame_i.bit9;
      // An all-zero address and mask make both hits true, which is the filter off.
      accept = rx_frame_i.valid && (ctrl_reg.mode != 2'h0) && !ri_reg &&
               (!ctrl_reg.multiproc_idle_level_bit ||
                (qualify && (given_hit || bcast_hit)));
      // A refused frame touches neither flag nor buffer.
      if (accept) begin
         rx_buf_next = rx_frame_i.data;
         rb8_next = (ctrl_reg.mode == 2'h1) ? rx_frame_i.stop_ok : rx_frame_i.bit9;
         set_ri = 1'b1;
      end

      // Shift rate and clock phase.
      if (ctrl_reg.timer_rate_select_bit) begin
         per = ctrl_reg.rate_double_bit ? `UAMS_DIV_TMR_X2 : `UAMS_DIV_TMR;
         src_ev = timer1_ovf_i;
      end else if (ctrl_reg.compat) begin
         per = ctrl_reg.rate_double_bit ? `UAMS_DIV_COMPAT_X2 : `UAMS_DIV_COMPAT;
         src_ev = 1'b1;
      end else begin
         per = ctrl_reg.rate_double_bit ? `UAMS_DIV_FAST_X2 : `UAMS_DIV_FAST;
         src_ev = 1'b1;
      end
      half = per >> 1;
      mid_ev = src_ev && (cnt_reg == half - 3'h1);
      end_ev = src_ev && (cnt_reg == per - 3'h1);
      // Low idle with doubled rate moves data on the mid-bit falling edge.
      chg_mid = ctrl_reg.multiproc_idle_level_bit && ctrl_reg.rate_double_bit;
      tx_ev = chg_mid ? mid_ev : end_ev;
      rx_ev = chg_mid ? end_ev : mid_ev;
      idle_lvl = !ctrl_reg.multiproc_idle_level_bit;
      din = ctrl_reg.three_wire ? miso_s2_reg : rxd_s2_reg;
      rx_shifted = {rx_sreg_reg[6:0], din};
      if (state_reg != uams_pkg::UAMS_IDLE && src_ev) begin
         cnt_next = (cnt_reg == per - 3'h1) ? 3'h0 : cnt_reg + 3'h1;
      end

      case (state_reg)
         uams_pkg::UAMS_IDLE: begin
            cnt_next = 3'h0;
            if (data_wr && ctrl_reg.mode == 2'h0) begin
               tx_sreg_next = {1'b1, w_data_reg[7:0]};
               tx_act_next = 1'b1;
               rx_act_next = ctrl_reg.three_wire && ctrl_reg.rx_enable;
               rx_sreg_next = `UAMS_RX_INIT;
               state_next = uams_pkg::UAMS_START;
            end else if (ctrl_reg.mode == 2'h0 && !ctrl_reg.three_wire &&
                         ctrl_reg.rx_enable && !ri_reg) begin
               rx_sreg_next = `UAMS_RX_INIT;
               rx_act_next = 1'b1;
               tx_act_next = 1'b0;
               state_next = uams_pkg::UAMS_SHIFT;
            end
         end
         uams_pkg::UAMS_START: begin
            // One bit slot passes before the send phase starts.
            if (end_ev) begin
               state_next = uams_pkg::UAMS_SHIFT;
            end
         end
         uams_pkg::UAMS_SHIFT: begin
            if (tx_act_reg && tx_ev) begin
               tx_sreg_next = {1'b0, tx_sreg_reg[8:1]};
               if (tx_sreg_reg[8:1] == `UAMS_TX_LAST) begin
                  tx_act_next = 1'b0;
                  set_ti = 1'b1;
               end
            end
            if (rx_act_reg && rx_ev) begin
               rx_sreg_next = rx_shifted;
               if (!rx_sreg_reg[7]) begin
                  rx_act_next = 1'b0;
                  rx_buf_next = reverse8(rx_shifted);
                  set_ri = 1'b1;
               end
            end
            if (!tx_act_next && !rx_act_next) begin
               state_next = uams_pkg::UAMS_IDLE;
            end
         end
         default: begin
            state_next = uams_pkg::UAMS_IDLE;
         end
      endcase

      // A flag event wins over a clear in the same cycle.
      ri_next = (ri_reg && !clr_ri) || set_ri;
      ti_next = (ti_reg && !clr_ti) || set_ti;
      irq_next = |({ti_next, ri_next} & irq_mask_reg);

      // First half of each bit (first third at the doubled compat rate) leaves the idle level.
      sclk = (state_reg == uams_pkg::UAMS_SHIFT && cnt_reg < half) ? !idle_lvl : idle_lvl;
      txd_next = (ctrl_reg.mode != 2'h0 || ctrl_reg.three_wire) ? 1'b1 : sclk;
      sck_next = ctrl_reg.three_wire ? sclk : idle_lvl;
      mosi_next = (ctrl_reg.three_wire && tx_act_reg) ? tx_sreg_reg[0] : 1'b1;
      if (ctrl_reg.mode != 2'h0 || ctrl_reg.three_wire) begin
         rxd_o_next = 1'b0;
         rxd_oe_next = 1'b0;
      end else if (tx_act_reg && state_reg == uams_pkg::UAMS_SHIFT) begin
         rxd_o_next = tx_sreg_reg[0];
         rxd_oe_next = 1'b1;
      end else if (rx_act_reg) begin
         rxd_o_next = 1'b0;
         rxd_oe_next = 1'b0;
      end else begin
         // The latch drives only a low so that a remote node may pull the line.
         rxd_o_next = 1'b0;
         rxd_oe_next = !ctrl_reg.data_pin_port_latch;
      end

      awready_next = !aw_have_next;
      wready_next = !w_have_next;
      arready_next = !rvalid_next;
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_have_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `UAMS_RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg <= `UAMS_RESP_OKAY;
         rdata_reg <= 32'h0000_0000;
         ctrl_reg <= `UAMS_CTRL_RST;
         slv_addr_reg <= `UAMS_SLV_ADDR_RST;
         slv_mask_reg <= `UAMS_SLV_MASK_RST;
         irq_mask_reg <= `UAMS_IRQ_MASK_RST;
         rx_buf_reg <= 8'h00;
         rb8_reg <= 1'b0;
         ri_reg <= 1'b0;
         ti_reg <= 1'b0;
         irq_reg <= 1'b0;
         state_reg <= uams_pkg::UAMS_IDLE;
         tx_sreg_reg <= 9'h000;
         rx_sreg_reg <= 8'h00;
         tx_act_reg <= 1'b0;
         rx_act_reg <= 1'b0;
         cnt_reg <= 3'h0;
         rxd_s1_reg <= 1'b1;
         rxd_s2_reg <= 1'b1;
         miso_s1_reg <= 1'b1;
         miso_s2_reg <= 1'b1;
         rxd_o_reg <= 1'b0;
         rxd_oe_reg <= 1'b0;
         txd_reg <= 1'b1;
         mosi_reg <= 1'b1;
         sck_reg <= 1'b1;
      end else begin
         aw_have_reg <= aw_have_next;
         aw_addr_reg <= aw_addr_next;
         w_have_reg <= w_have_next;
         w_data_reg <= w_data_next;
         w_strb_reg <= w_strb_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         bvalid_reg <= bvalid_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next;
         rvalid_reg <= rvalid_next;
         rresp_reg <= rresp_next;
         rdata_reg <= rdata_next;
         ctrl_reg <= ctrl_next;
         slv_addr_reg <= slv_addr_next;
         slv_mask_reg <= slv_mask_next;
         irq_mask_reg <= irq_mask_next;
         rx_buf_reg <= rx_buf_next;
         rb8_reg <= rb8_next;
         ri_reg <= ri_next;
         ti_reg <= ti_next;
         irq_reg <= irq_next;
         state_reg <= state_next;
         tx_sreg_reg <= tx_sreg_next;
         rx_sreg_reg <= rx_sreg_next;
         tx_act_reg <= tx_act_next;
         rx_act_reg <= rx_act_next;
         cnt_reg <= cnt_next;
         rxd_s1_reg <= rxd_i;
         rxd_s2_reg <= rxd_s1_reg;
         miso_s1_reg <= miso_i;
         miso_s2_reg <= miso_s1_reg;
         rxd_o_reg <= rxd_o_next;
         rxd_oe_reg <= rxd_oe_next;
         txd_reg <= txd_next;
         mosi_reg <= mosi_next;
         sck_reg <= sck_next;
      end
   end

endmodule

// File: pkg/uams_defines.svh
/*
 Constants of the serial port address filter and shift engine: register word indices,
 field positions, reset values and rate divisors.
 Assumes it is included by its bare name from the top module.

*/
`ifndef UAMS_DEFINES_SVH
`define UAMS_DEFINES_SVH

// Word indices; the byte address is four times the index.
`define UAMS_WIDX_CTRL 10'h000
`define UAMS_WIDX_DATA 10'h001
`define UAMS_WIDX_STATUS 10'h002
`define UAMS_WIDX_IRQ_MASK 10'h003
`define UAMS_WIDX_SLV_ADDR 10'h0a9
`define UAMS_WIDX_SLV_MASK 10'h0b9

`define UAMS_ST_RX_DONE 0
`define UAMS_ST_TX_DONE 1
`define UAMS_ST_RB8 2

`define UAMS_CTRL_RST 9'h100
`define UAMS_SLV_ADDR_RST 8'h00
`define UAMS_SLV_MASK_RST 8'h00
`define UAMS_IRQ_MASK_RST 2'h0

`define UAMS_DIV_FAST 3'h4
`define UAMS_DIV_FAST_X2 3'h2
`define UAMS_DIV_COMPAT 3'h6
`define UAMS_DIV_COMPAT_X2 3'h3
`define UAMS_DIV_TMR 3'h4
`define UAMS_DIV_TMR_X2 3'h2

`define UAMS_RX_INIT 8'hfe
`define UAMS_TX_LAST 8'h01

`define UAMS_RESP_OKAY 2'h0
`define UAMS_RESP_SLVERR 2'h2

`endif

// File: pkg/uams_pkg.sv
/*
 Types of the serial port address filter and shift engine.
 Assumes the constants header sits beside it.
*/
package uams_pkg;

   typedef struct packed {
      logic data_pin_port_latch;
      logic three_wire;
      logic compat;
      logic timer_rate_select_bit;
      logic rate_double_bit;
      logic rx_enable;
      logic multiproc_idle_level_bit;
      logic [1:0] mode;
   } uams_ctrl_t;

   typedef struct packed {
      logic valid;
      logic stop_ok;
      logic bit9;
      logic [7:0] data;
   } uams_frame_t;

   typedef enum logic [2:0] {
      UAMS_IDLE = 3'b001,
      UAMS_START = 3'b010,
      UAMS_SHIFT = 3'b100
   } uams_state_t;

   typedef enum logic [2:0] {
      UAMS_R_NONE = 3'h0,
      UAMS_R_CTRL = 3'h1,
      UAMS_R_DATA = 3'h2,
      UAMS_R_STATUS = 3'h3,
      UAMS_R_IRQ_MASK = 3'h4,
      UAMS_R_SLV_ADDR = 3'h5,
      UAMS_R_SLV_MASK = 3'h6
   } uams_reg_t;

endpackage

// File: test/uams_top_properties.sv
/*
 Checker for the bus handshakes and the shift clock of uams_top.
 Assumes it is bound to uams_top and sees only its ports.
*/
`timescale 1ns/1ps
module uams_properties (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Bus
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   // Shift clock
   input wire logic txd_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
      s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write answer dropped");
   a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
      s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read answer dropped");
   a_aw_busy: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
      else $error("address taken twice");
   a_ar_busy: assert property (s_axi_arvalid_i && s_axi_arready_o |=> !s_axi_arready_o)
      else $error("read address taken twice");
   a_r_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_b_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
      s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
   a_b_code: assert property (s_axi_bvalid_o |-> !s_axi_bresp_o[0])
      else $error("bad write response");
   a_clk_half: assert property ($fell(txd_o) |-> ##[1:300] $rose(txd_o))
      else $error("shift clock stuck low");
   cover property (s_axi_bvalid_o && s_axi_bresp_o == 2'h2);
   cover property ($fell(txd_o));
   cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule
bind uams_top uams_properties uams_properties_inst (.sys_clk_i, .rst_n_i, .s_axi_awvalid_i,
   .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i,
   .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
   .s_axi_rdata_o, .txd_o);

// File: test/uams_peer_model.sv
/*
 Two-wire shift peer: captures the bytes it is sent and answers with one byte.
 Assumes an idle-high shift clock with data sampled on its rising edge.
*/
`timescale 1ns/1ps
module uams_peer_model (
   // Pins
   input wire logic sck_i,
   input wire logic oe_i,
   input wire logic dout_i,
   output logic line_o,
   // Control
   input wire logic en_i,
   input wire logic [7:0] send_i,
   output logic [7:0] got_o
);
   logic [2:0] idx = 3'h0;
   // A released line reads high through the port pull-up.
   assign line_o = oe_i ? dout_i : (en_i ? send_i[idx] : 1'h1);
   always @(posedge sck_i) begin
      got_o <= {line_o, got_o[7:1]};
   end
   always @(posedge sck_i or negedge en_i) begin
      if (!en_i)
         idx <= 3'h0;
      else
         idx <= idx + 3'h1;
   end
endmodule

// File: test/uams_top_tb.sv
/*
 Bench for uams_top: bus tasks, shift rates, two-wire receive, address filter.
 Assumes the peer model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
module uams_top_tb;
   logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
   logic tmr = 1'h0, pen = 1'h0, tp = 1'h1, erb = 1'h0;
   logic awr, wrd, bv, arr, rv, irq, rxo, oe, txd, line, mosi, sck;
   logic [11:0] awa = 12'h0, ara = 12'h0;
   logic [31:0] wd = 32'h0, rdat, v;
   logic [1:0] bresp, rresp, r;
   logic [7:0] got, got3, eb;
   logic [14:0] e;
   uams_pkg::uams_frame_t frm = '0;
   int err_total = 0, cmp_count = 0, cyc = 0, nf = 0, ff = 0, lf = 0;
   logic [31:0] ctl [0:5] = '{32'h100, 32'h110, 32'h140, 32'h150, 32'h120, 32'h130};
   int per [0:5] = '{4, 2, 6, 3, 12, 6};
   logic [14:0] ftab [0:8] = '{15'h37c0, 15'h37c2, 15'h36c1, 15'h32c0, 15'h37fd, 15'h28c0,
      15'h2bc0, 15'h13c1, 15'h06c0};
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      tmr <= (cyc % 3 == 0);
      tp <= txd;
      if (tp && !txd) begin
         nf <= nf + 1;
         lf <= cyc;
         if (nf == 0)
            ff <= cyc;
      end
   end
   uams_top uams_top_inst (.sys_clk_i(clk), .rst_n_i(rst_n), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'h3),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(br), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
      .rx_frame_i(frm), .timer1_ovf_i(tmr), .rxd_i(line), .rxd_o(rxo), .rxd_oe_o(oe),
      .txd_o(txd), .miso_i(1'h1), .mosi_o(mosi), .sck_o(sck), .irq_o(irq));
   uams_peer_model uams_peer_model_inst (.sck_i(txd), .oe_i(oe), .dout_i(rxo), .line_o(line),
      .en_i(pen), .send_i(8'h3c), .got_o(got));
   uams_peer_model uams_peer_model_spi_inst (.sck_i(sck), .oe_i(1'h1), .dout_i(mosi),
      .line_o(), .en_i(1'h0), .send_i(8'h00), .got_o(got3));
   task automatic wrap_up();
      if (err_total == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      cmp_count++;
      if (g !== x) begin
         err_total++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, x);
      end
   endtask
   task automatic hang();
      err_total++;
      $display("CHECK FAILED %0t wait ran out", $time);
      wrap_up();
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic dn;
      dn = 1'h0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      br <= 1'h1;
      for (int n = 0; !dn; n++) begin
         if (n > 200)
            hang();
         @(posedge clk);
         if (awr)
            awv <= 1'h0;
         if (wrd)
            wv <= 1'h0;
         if (bv) begin
            r = bresp;
            br <= 1'h0;
            dn = 1'h1;
         end
      end
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      logic dn;
      dn = 1'h0;
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rr <= 1'h1;
      for (int n = 0; !dn; n++) begin
         if (n > 200)
            hang();
         @(posedge clk);
         if (arr)
            arv <= 1'h0;
         if (rv) begin
            d = rdat;
            r = rresp;
            rr <= 1'h0;
            dn = 1'h1;
         end
      end
   endtask
   task automatic poll(input int b);
      v = 32'h0;
      for (int n = 0; !v[b]; n++) begin
         if (n > 400)
            hang();
         rd(12'h008, v);
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      rd(12'h2a4, v);
      chk(v, 32'h0);
      rd(12'h2e4, v);
      chk(v, 32'h0);
      chk(txd, 1'h1);
      rd(12'h040, v);
      chk(r, 2'h2);
      wr(12'h040, 32'h1);
      chk(r, 2'h2);
      wr(12'h000, 32'h104);
      @(posedge clk);
      chk(txd, 1'h0);
      for (int i = 0; i < 6; i++) begin
         wr(12'h000, ctl[i]);
         wr(12'h008, 32'h3);
         nf <= 0;
         wr(12'h004, 32'h96);
         poll(1);
         chk(got, 8'h96);
         chk(nf, 8);
         chk(lf - ff, 7 * per[i]);
      end
      chk(irq, 1'h0);
      wr(12'h000, 32'h188);
      wr(12'h008, 32'h3);
      wr(12'h004, 32'h5a);
      poll(1);
      chk(got3, 8'h5a);
      rd(12'h004, v);
      chk(v, 32'hff);
      pen <= 1'h1;
      wr(12'h00c, 32'h1);
      wr(12'h008, 32'h3);
      wr(12'h000, 32'h108);
      poll(0);
      rd(12'h004, v);
      chk(v, 32'h3c);
      chk(irq, 1'h1);
      wr(12'h000, 32'h100);
      wr(12'h008, 32'h1);
      @(posedge clk);
      chk(irq, 1'h0);
      pen <= 1'h0;
      eb = 8'h3c;
      wr(12'h2a4, 32'hc0);
      wr(12'h2e4, 32'hfd);
      for (int i = 0; i < 9; i++) begin
         e = ftab[i];
         wr(12'h000, {28'h010, e[14:11]});
         wr(12'h008, 32'h3);
         frm <= {1'h1, e[9], e[10], e[7:0]};
         @(posedge clk);
         frm <= '0;
         if (e[8]) begin
            eb = e[7:0];
            erb = (e[12:11] == 2'h1) ? e[9] : e[10];
         end
         rd(12'h008, v);
         chk(v[2:0] & 3'h5, {erb, 1'h0, e[8]});
         rd(12'h004, v);
         chk(v, {24'h0, eb});
      end
      wrap_up();
   end
endmodule
